// ==== timer16_pkg.sv ====
// Purpose: Shared constants and carriers for the 16-bit timer with input capture.
// Assumes: One system clock; CPU byte accesses arrive as single-cycle strobes.
// Notes:   Every offset, reset value and count used by more than one file lives here.
package timer16_pkg;

  localparam int          COUNT_W      = 16;
  localparam int          BYTE_W       = 8;
  localparam int          FILTER_LEN   = 4;
  localparam int          SYNC_STAGES  = 2;

  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT     = 16'h00ff;
  localparam logic [15:0] TOP_9BIT     = 16'h01ff;
  localparam logic [15:0] TOP_10BIT    = 16'h03ff;

  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic [15:0] CAPTURE_RST  = 16'h0000;
  localparam logic [7:0]  LATCH_RST    = 8'h00;
  localparam logic [7:0]  RDATA_RST    = 8'h00;
  localparam logic [2:0]  CLK_STOPPED  = 3'h0;

  // Byte locations seen by the CPU.
  typedef enum logic [1:0] {
    LOC_COUNT_LOWER   = 2'b00,
    LOC_COUNT_UPPER   = 2'b01,
    LOC_CAPTURE_LOWER = 2'b10,
    LOC_CAPTURE_UPPER = 2'b11
  } loc_e;

  typedef struct packed {
    logic       rd;
    logic       wr;
    loc_e       loc;
    logic [7:0] wdata;
  } cpu_req_s;

  typedef struct packed {
    logic [15:0] top;
    logic        dual_slope;
    logic        capture_is_top;
    logic        ovf_at_top;
    logic        ovf_at_bottom;
  } mode_info_s;

endpackage

// ==== timer16_mode_decode.sv ====
// Purpose: Turns the waveform mode field into top value and counting style.
// Assumes: Compare and capture top values are stable register outputs.
// Notes:   Mode 13 has no defined sequence and behaves as normal counting.
`timescale 1ns/1ps
module timer16_mode_decode
  import timer16_pkg::*;
(
  input  wire logic [3:0]  waveform_mode_field, // Selected waveform mode
  input  wire logic [15:0] compare_top,         // Top from the compare unit
  input  wire logic [15:0] capture_top,         // Top from the capture register
  output timer16_pkg::mode_info_s info          // Decoded counting style
);
  import timer16_pkg::*;

  always_comb begin
    info = '{top: COUNT_MAX, dual_slope: 1'b0, capture_is_top: 1'b0,
             ovf_at_top: 1'b0, ovf_at_bottom: 1'b0};
    unique case (waveform_mode_field)
      4'h1, 4'h5: info.top = TOP_8BIT;
      4'h2, 4'h6: info.top = TOP_9BIT;
      4'h3, 4'h7: info.top = TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: info.top = compare_top;
      4'h8, 4'ha, 4'hc, 4'he: info.top = capture_top;
      4'h0, 4'hd: info.top = COUNT_MAX;
    endcase
    info.capture_is_top = (waveform_mode_field == 4'h8) || (waveform_mode_field == 4'ha) ||
                          (waveform_mode_field == 4'hc) || (waveform_mode_field == 4'he);
    info.dual_slope     = (waveform_mode_field inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha,
                                                       4'hb});
    info.ovf_at_bottom  = info.dual_slope;
    info.ovf_at_top     = (waveform_mode_field inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf});
  end

endmodule

// ==== capture_conditioner.sv ====
// Purpose: Synchronises the capture sources, filters them and detects the chosen edge.
// Assumes: Pin and comparator levels are asynchronous to ref_clk.
// Notes:   The filter adds four cycles of delay when enabled.
`timescale 1ns/1ps
module capture_conditioner
  import timer16_pkg::*;
(
  input  wire logic ref_clk,                   // System clock
  input  wire logic rstn,                      // Asynchronous reset, active low
  input  wire logic capture_pin,               // Capture pin level
  input  wire logic comparator_output,         // Comparator output level
  input  wire logic comparator_capture_select, // Take comparator instead of pin
  input  wire logic noise_filter_enable,       // Enable the four-sample filter
  input  wire logic capture_edge_rising,       // 1 rising, 0 falling
  input  wire logic detect_enable,             // Low while capture defines top
  output logic      capture_event              // One-cycle capture trigger
);
  import timer16_pkg::*;

  logic [SYNC_STAGES-1:0] pin_sync_reg, pin_sync_next;
  logic [SYNC_STAGES-1:0] cmp_sync_reg, cmp_sync_next;
  logic [FILTER_LEN-1:0]  hist_reg, hist_next;
  logic                   level_reg, level_next;
  logic                   prev_reg, prev_next;
  logic                   source;

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers
  always_comb begin
    pin_sync_next = {pin_sync_reg[0], capture_pin};
    cmp_sync_next = {cmp_sync_reg[0], comparator_output};
    source        = comparator_capture_select ? cmp_sync_reg[1] : pin_sync_reg[1];
    hist_next     = {hist_reg[FILTER_LEN-2:0], source};
    level_next    = level_reg;
    prev_next     = level_reg;
    if (!noise_filter_enable) begin
      level_next = source;
    end else if (&hist_reg) begin
      level_next = 1'b1;
    end else if (~|hist_reg) begin
      level_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_sync_reg <= '0;
      cmp_sync_reg <= '0;
      hist_reg     <= '0;
      level_reg    <= 1'b0;
      prev_reg     <= 1'b0;
    end else begin
      pin_sync_reg <= pin_sync_next;
      cmp_sync_reg <= cmp_sync_next;
      hist_reg     <= hist_next;
      level_reg    <= level_next;
      prev_reg     <= prev_next;
    end
  end

  assign capture_event = detect_enable && (level_reg != prev_reg) &&
                         (level_reg == capture_edge_rising);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_filter_agree: assert property (
    noise_filter_enable && $changed(level_reg) |->
      $past(hist_reg) == {FILTER_LEN{level_reg}})
    else $error("filtered level changed without four equal samples");

endmodule

// ==== timer16_capture.sv ====
// Purpose: 16-bit up/down timer counter with input capture and byte access.
// Assumes: timer_tick is a one-cycle pulse from the prescaler on ref_clk.
// Notes:   The CPU sees four byte locations sharing one high-byte latch.
`timescale 1ns/1ps

// Notes on behaviour
// - Sixteen-bit counter, steps by one, up/down.
// - Clear forces every counter bit to zero.
// - Bottom at zero, top chosen by mode.
// - Count seen as upper and lower bytes.
// - Upper count location reaches only latch.
// - Lower read latches upper; lower write loads.
// - Clock select zero stops counting; access stays.
// - CPU count write beats clear or count.
// - Waveform mode field chooses counting sequence.
// - Overflow flag point depends on mode.
// - Selected edge copies count into capture.
// - Capture flag set with capture copy.
// - Flag requests interrupt; ack or one clears.
// - Capture read low first, high from latch.
// - Capture writable only when it is top.
// - Comparator select switches source; clear flag after.
// - Filter output changes after four equal samples.
// - Filter adds four clocks of delay.
// - Filter samples system clock, not tick.
// - Detection off when capture defines top.
// - New capture overwrites unread capture value.
// - Port-driven pin triggers capture like external.
module timer16_capture
  import timer16_pkg::*;
(
  input  wire logic              ref_clk,                   // System clock, 40 MHz
  input  wire logic              rstn,                      // Async reset, active low
  input  wire timer16_pkg::cpu_req_s cpu_req,               // CPU byte access strobe
  output logic [7:0]             cpu_rdata,                 // Read data, next cycle
  input  wire logic              timer_tick,                // Prescaled tick pulse
  input  wire logic [2:0]        clock_select_field,        // Zero stops the timer
  input  wire logic [3:0]        waveform_mode_field,       // Counting sequence
  input  wire logic [15:0]       compare_top,               // Top from compare unit
  input  wire logic              capture_pin,               // Capture pin level
  input  wire logic              comparator_output,         // Comparator level
  input  wire logic              comparator_capture_select, // Comparator as source
  input  wire logic              noise_filter_enable,       // Filter enable
  input  wire logic              capture_edge_rising,       // 1 rising, 0 falling
  input  wire logic              capture_irq_enable,        // Capture irq enable
  input  wire logic              overflow_irq_enable,       // Overflow irq enable
  input  wire logic              capture_flag_clear,        // Write-one clear pulse
  input  wire logic              overflow_flag_clear,       // Write-one clear pulse
  input  wire logic              capture_irq_ack,           // Capture irq serviced
  input  wire logic              overflow_irq_ack,          // Overflow irq serviced
  output logic [15:0]            timer_count,               // Counter value
  output logic                   count_down,                // Direction, 1 down
  output logic                   top_reached,               // Count equals top
  output logic                   bottom_reached,            // Count equals zero
  output logic [15:0]            capture_value,             // Capture register
  output logic                   capture_flag,              // Capture flag
  output logic                   overflow_flag,             // Overflow flag
  output logic                   capture_irq,               // Capture request
  output logic                   overflow_irq               // Overflow request
);
  import timer16_pkg::*;

  logic [15:0] count_reg, count_next;
  logic        down_reg, down_next;
  logic [15:0] capture_reg, capture_next;
  logic [7:0]  latch_reg, latch_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        cap_flag_reg, cap_flag_next;
  logic        ovf_flag_reg, ovf_flag_next;
  mode_info_s  info;
  logic        capture_event;
  logic        step;
  logic        ovf_event;

  function automatic logic hit(input cpu_req_s r, input loc_e l, input logic w);
    hit = (w ? r.wr : r.rd) && (r.loc == l);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  timer16_mode_decode u_mode (
    .waveform_mode_field (waveform_mode_field),
    .compare_top         (compare_top),
    .capture_top         (capture_reg),
    .info                (info)
  );

  capture_conditioner u_cond (
    .ref_clk                   (ref_clk),
    .rstn                      (rstn),
    .capture_pin               (capture_pin),
    .comparator_output         (comparator_output),
    .comparator_capture_select (comparator_capture_select),
    .noise_filter_enable       (noise_filter_enable),
    .capture_edge_rising       (capture_edge_rising),
    .detect_enable             (!info.capture_is_top),
    .capture_event             (capture_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter unit.
  always_comb begin
    count_next = count_reg;
    down_next  = down_reg;
    ovf_event  = 1'b0;
    step       = timer_tick && (clock_select_field != CLK_STOPPED);
    if (step && info.dual_slope) begin
      if (!down_reg && (count_reg == info.top)) begin
        down_next  = 1'b1;
        count_next = count_reg - 16'h0001;
      end else if (down_reg && (count_reg == COUNT_BOTTOM)) begin
        down_next  = 1'b0;
        count_next = count_reg + 16'h0001;
        ovf_event  = info.ovf_at_bottom;
      end else begin
        count_next = down_reg ? count_reg - 16'h0001 : count_reg + 16'h0001;
      end
    end else if (step) begin
      down_next = 1'b0;
      ovf_event = info.ovf_at_top ? (count_reg == info.top) : (count_reg == COUNT_MAX);
      if (count_reg == info.top) begin
        count_next = COUNT_BOTTOM;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end
    if (hit(cpu_req, LOC_COUNT_LOWER, 1'b1)) begin
      count_next = {latch_reg, cpu_req.wdata};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= COUNT_RST;
      down_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      down_reg  <= down_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture register, shared latch and read data.
  always_comb begin
    capture_next = capture_reg;
    latch_next   = latch_reg;
    rdata_next   = rdata_reg;
    if (capture_event) begin
      capture_next = count_reg;
    end else if (hit(cpu_req, LOC_CAPTURE_LOWER, 1'b1) && info.capture_is_top) begin
      capture_next = {latch_reg, cpu_req.wdata};
    end
    if (hit(cpu_req, LOC_COUNT_UPPER, 1'b1) || hit(cpu_req, LOC_CAPTURE_UPPER, 1'b1)) begin
      latch_next = cpu_req.wdata;
    end
    if (cpu_req.rd) begin
      unique case (cpu_req.loc)
        LOC_COUNT_LOWER: begin
          rdata_next = count_reg[7:0];
          latch_next = count_reg[15:8];
        end
        LOC_CAPTURE_LOWER: begin
          rdata_next = capture_reg[7:0];
          latch_next = capture_reg[15:8];
        end
        LOC_COUNT_UPPER, LOC_CAPTURE_UPPER: begin
          rdata_next = latch_reg;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      capture_reg <= CAPTURE_RST;
      latch_reg   <= LATCH_RST;
      rdata_reg   <= RDATA_RST;
    end else begin
      capture_reg <= capture_next;
      latch_reg   <= latch_next;
      rdata_reg   <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags; a setting event wins over a clear in the same cycle.
  always_comb begin
    cap_flag_next = cap_flag_reg;
    ovf_flag_next = ovf_flag_reg;
    if (capture_flag_clear || capture_irq_ack) begin
      cap_flag_next = 1'b0;
    end
    if (capture_event) begin
      cap_flag_next = 1'b1;
    end
    if (overflow_flag_clear || overflow_irq_ack) begin
      ovf_flag_next = 1'b0;
    end
    if (ovf_event) begin
      ovf_flag_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cap_flag_reg <= 1'b0;
      ovf_flag_reg <= 1'b0;
    end else begin
      cap_flag_reg <= cap_flag_next;
      ovf_flag_reg <= ovf_flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign timer_count    = count_reg;
  assign count_down     = down_reg;
  assign capture_value  = capture_reg;
  assign cpu_rdata      = rdata_reg;
  assign capture_flag   = cap_flag_reg;
  assign overflow_flag  = ovf_flag_reg;
  assign top_reached    = (count_reg == info.top);
  assign bottom_reached = (count_reg == COUNT_BOTTOM);
  assign capture_irq    = cap_flag_reg && capture_irq_enable;
  assign overflow_irq   = ovf_flag_reg && overflow_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_write_priority: assert property (
    cpu_req.wr && cpu_req.loc == LOC_COUNT_LOWER |=>
      count_reg == {$past(latch_reg), $past(cpu_req.wdata)})
    else $error("CPU count write did not take priority");

  a_stopped_hold: assert property (
    clock_select_field == CLK_STOPPED && !(cpu_req.wr && cpu_req.loc == LOC_COUNT_LOWER)
      |=> $stable(count_reg))
    else $error("counter moved while stopped");

  a_step_one: assert property (
    step && !info.dual_slope && !cpu_req.wr && count_reg != info.top |=>
      count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not step by one");

  a_top_clear: assert property (
    step && !info.dual_slope && !cpu_req.wr && count_reg == info.top |=>
      count_reg == COUNT_BOTTOM)
    else $error("counter not cleared at top");

  a_capture_copy: assert property (
    capture_event |=> capture_reg == $past(count_reg) && cap_flag_reg)
    else $error("capture did not copy count with flag");

  a_flag_set_wins: assert property (
    capture_event && capture_flag_clear |=> cap_flag_reg)
    else $error("capture event lost against clear");

  a_flag_clear: assert property (
    !capture_event && capture_irq_ack |=> !cap_flag_reg)
    else $error("capture flag not cleared by ack");

  a_lower_read_latch: assert property (
    cpu_req.rd && cpu_req.loc == LOC_COUNT_LOWER ##1
      cpu_req.rd && cpu_req.loc == LOC_COUNT_UPPER |=>
      cpu_rdata == $past(count_reg[15:8], 2))
    else $error("upper count byte not returned from latch");

  a_upper_write_latch: assert property (
    cpu_req.wr && cpu_req.loc == LOC_COUNT_UPPER && !step |=>
      latch_reg == $past(cpu_req.wdata) && count_reg == $past(count_reg))
    else $error("upper write reached counter or missed latch");

  a_capture_write_gate: assert property (
    cpu_req.wr && cpu_req.loc == LOC_CAPTURE_LOWER && !info.capture_is_top &&
      !capture_event |=> $stable(capture_reg))
    else $error("capture written outside top mode");

  a_detect_off: assert property (
    info.capture_is_top && !(cpu_req.wr && cpu_req.loc == LOC_CAPTURE_LOWER) |=>
      $stable(capture_reg) && !$rose(cap_flag_reg))
    else $error("capture triggered while capture defines top");

endmodule

// ==== cpu_model.sv ====
// Purpose: Behavioural CPU core issuing byte accesses to the timer.
// Assumes: Strobes change 1 ns after a rising edge of ref_clk.
// Notes:   Idle cycles show inverted location and data, never the last value.
`timescale 1ns/1ps
module cpu_model
  import timer16_pkg::*;
(
  input  wire logic             ref_clk,   // System clock
  input  wire logic [7:0]       cpu_rdata, // Read data from the timer
  output timer16_pkg::cpu_req_s cpu_req    // Byte access strobe
);
  initial cpu_req = '0;

  ////////////////////////////////////////////////////////////////////////////
  task automatic access(input logic rd, input logic wr, input loc_e loc,
                        input logic [7:0] d, output logic [7:0] q);
    cpu_req = '{rd: rd, wr: wr, loc: loc, wdata: d};
    @(posedge ref_clk);
    #1;
    q = cpu_rdata;
  endtask

  task automatic wr16(input loc_e lower, input logic [15:0] v);
    logic [7:0] q;
    access(1'b0, 1'b1, loc_e'({lower[1], 1'b1}), v[15:8], q);
    access(1'b0, 1'b1, lower, v[7:0], q);
  endtask

  task automatic rd16(input loc_e lower, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    access(1'b1, 1'b0, lower, 8'h00, lo);
    access(1'b1, 1'b0, loc_e'({lower[1], 1'b1}), 8'h00, hi);
    v = {hi, lo};
  endtask

  task automatic idle();
    cpu_req = '{rd: 1'b0, wr: 1'b0, loc: loc_e'(~cpu_req.loc), wdata: ~cpu_req.wdata};
    @(posedge ref_clk);
    #1;
  endtask
endmodule

// ==== timer16_counter_input_capture_tb.sv ====
// Purpose: Self-checking bench for the 16-bit timer with input capture.
// Assumes: Inputs change 1 ns after the rising edge of ref_clk.
// Notes:   The counter is stopped during capture tests so stamps are known.
`timescale 1ns/1ps
module timer16_counter_input_capture_tb;
  import timer16_pkg::*;
  logic ref_clk, rstn, timer_tick, capture_pin, comparator_output, comparator_capture_select;
  logic noise_filter_enable, capture_edge_rising, capture_irq_enable, overflow_irq_enable;
  logic capture_flag_clear, overflow_flag_clear, capture_irq_ack, overflow_irq_ack;
  logic count_down, top_reached, bottom_reached, capture_flag, overflow_flag;
  logic capture_irq, overflow_irq;
  logic [2:0]  clock_select_field;
  logic [3:0]  waveform_mode_field;
  logic [15:0] compare_top, timer_count, capture_value, v;
  logic [7:0]  cpu_rdata, q;
  cpu_req_s    cpu_req;
  int          bad_count, compares;

  cpu_model cpu (.ref_clk(ref_clk), .cpu_rdata(cpu_rdata), .cpu_req(cpu_req));
  timer16_capture dut (.ref_clk(ref_clk), .rstn(rstn), .cpu_req(cpu_req),
    .cpu_rdata(cpu_rdata), .timer_tick(timer_tick), .clock_select_field(clock_select_field),
    .waveform_mode_field(waveform_mode_field), .compare_top(compare_top),
    .capture_pin(capture_pin), .comparator_output(comparator_output),
    .comparator_capture_select(comparator_capture_select),
    .noise_filter_enable(noise_filter_enable), .capture_edge_rising(capture_edge_rising),
    .capture_irq_enable(capture_irq_enable), .overflow_irq_enable(overflow_irq_enable),
    .capture_flag_clear(capture_flag_clear), .overflow_flag_clear(overflow_flag_clear),
    .capture_irq_ack(capture_irq_ack), .overflow_irq_ack(overflow_irq_ack),
    .timer_count(timer_count), .count_down(count_down), .top_reached(top_reached),
    .bottom_reached(bottom_reached), .capture_value(capture_value),
    .capture_flag(capture_flag), .overflow_flag(overflow_flag),
    .capture_irq(capture_irq), .overflow_irq(overflow_irq));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    timer_tick = 1'b1;
    cyc(n);
    timer_tick = 1'b0;
    cyc(1);
  endtask

  task automatic set_count(input logic [15:0] c);
    cpu.wr16(LOC_COUNT_LOWER, c);
    cpu.idle();
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("count", timer_count, 16'h0000);
    chk("capture", capture_value, 16'h0000);
    chk("flags", {capture_flag, overflow_flag}, 16'h0000);
    chk("bottom", bottom_reached, 16'h0001);
  endtask

  task automatic t_bytes();
    set_count(16'h01ff);
    chk("count write", timer_count, 16'h01ff);
    tick(1);
    chk("stopped", timer_count, 16'h01ff);
    cpu.access(1'b0, 1'b1, LOC_COUNT_UPPER, 8'h7e, q);
    cpu.idle();
    chk("upper write", timer_count, 16'h01ff);
    cpu.rd16(LOC_COUNT_LOWER, v);
    cpu.idle();
    chk("count read", v, 16'h01ff);
  endtask

  task automatic t_count();
    clock_select_field = 3'h1;
    set_count(16'hfffe);
    tick(1);
    chk("step up", timer_count, 16'hffff);
    chk("top", top_reached, 16'h0001);
    tick(1);
    chk("wrap", timer_count, 16'h0000);
    chk("ovf irq", {overflow_flag, overflow_irq}, 16'h0003);
    overflow_flag_clear = 1'b1;
    cyc(1);
    overflow_flag_clear = 1'b0;
    cyc(1);
    chk("ovf clear", overflow_flag, 16'h0000);
    timer_tick = 1'b1;
    cpu.wr16(LOC_COUNT_LOWER, 16'h1234);
    chk("write wins", timer_count, 16'h1234);
    timer_tick = 1'b0;
    cpu.idle();
    waveform_mode_field = 4'h1;
    set_count(16'h00fe);
    tick(1);
    tick(1);
    chk("dual slope", timer_count, 16'h00fe);
    chk("direction", count_down, 16'h0001);
    waveform_mode_field = 4'h0;
    clock_select_field = 3'h0;
  endtask

  task automatic t_capture();
    set_count(16'h4321);
    capture_pin = 1'b1;
    cyc(5);
    chk("capture", capture_value, 16'h4321);
    chk("cap irq", {capture_flag, capture_irq}, 16'h0003);
    capture_irq_ack = 1'b1;
    cyc(1);
    capture_irq_ack = 1'b0;
    cyc(1);
    chk("ack", capture_flag, 16'h0000);
    set_count(16'h0555);
    capture_edge_rising = 1'b0;
    capture_pin = 1'b0;
    capture_flag_clear = 1'b1;
    cyc(4);
    chk("set wins", capture_flag, 16'h0001);
    chk("overwrite", capture_value, 16'h0555);
    cyc(1);
    capture_flag_clear = 1'b0;
    capture_pin = 1'b1;
    cyc(6);
    chk("wrong edge", capture_flag, 16'h0000);
    cpu.rd16(LOC_CAPTURE_LOWER, v);
    cpu.idle();
    chk("cap read", v, 16'h0555);
  endtask

  task automatic t_filter();
    noise_filter_enable = 1'b1;
    set_count(16'h0777);
    capture_pin = 1'b0;
    cyc(7);
    chk("filter delay", capture_flag, 16'h0000);
    cyc(1);
    chk("filtered", capture_flag, 16'h0001);
    chk("filtered value", capture_value, 16'h0777);
    capture_flag_clear = 1'b1;
    cyc(1);
    capture_flag_clear = 1'b0;
    capture_pin = 1'b1;
    cyc(3);
    capture_pin = 1'b0;
    cyc(10);
    chk("glitch", capture_flag, 16'h0000);
    noise_filter_enable = 1'b0;
    capture_edge_rising = 1'b1;
    comparator_output = 1'b1;
    cyc(6);
    chk("cmp unselected", capture_flag, 16'h0000);
    comparator_capture_select = 1'b1;
    cyc(5);
    chk("cmp source", capture_flag, 16'h0001);
    capture_flag_clear = 1'b1;
    cyc(1);
    capture_flag_clear = 1'b0;
    cyc(1);
    chk("cmp clear", capture_flag, 16'h0000);
    comparator_capture_select = 1'b0;
    cyc(6);
  endtask

  task automatic t_top_mode();
    capture_flag_clear = 1'b1;
    cpu.wr16(LOC_CAPTURE_LOWER, 16'h1111);
    capture_flag_clear = 1'b0;
    cpu.idle();
    chk("cap refused", capture_value, 16'h0777);
    waveform_mode_field = 4'hc;
    cpu.wr16(LOC_CAPTURE_LOWER, 16'h0abc);
    cpu.idle();
    chk("cap as top", capture_value, 16'h0abc);
    capture_pin = 1'b1;
    cyc(8);
    chk("gated", capture_flag, 16'h0000);
    chk("gated value", capture_value, 16'h0abc);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, timer_tick, capture_pin, comparator_output, comparator_capture_select} = '0;
    {noise_filter_enable, capture_irq_enable, capture_flag_clear, overflow_flag_clear} = '0;
    {capture_irq_ack, overflow_irq_ack} = '0;
    capture_edge_rising = 1'b1;
    capture_irq_enable = 1'b1;
    overflow_irq_enable = 1'b1;
    clock_select_field = 3'h0;
    waveform_mode_field = 4'h0;
    compare_top = 16'h00ff;
    bad_count = 0;
    compares = 0;
    cyc(6);
    rstn = 1'b1;
    cyc(1);
    t_reset();
    t_bytes();
    t_count();
    t_capture();
    t_filter();
    t_top_mode();
    complete_run();
  end

  initial begin
    #75000;
    bad_count++;
    complete_run();
  end
endmodule
